// ---- ras_host.sv ----
`timescale 1ns/100ps
module ras_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link
  ras_if.host link
);
  // ***************************************************
  // register bus
  // ***************************************************
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [15:0] word_ff;
  logic en_n_ff;
  logic pup_ff;
  logic done_ff;
  logic [15:0] rx_ff;
  logic req;
  logic wr;
  logic start;
  logic finish;
  ras_pkg::ras_host_state_e state_ff;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // writes land at the edge where the master sees ack high, never earlier
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign start = wr && wb_adr_i == ras_pkg::REG_CTRL && wb_sel_i[0] &&
                 wb_dat_i[ras_pkg::CTRL_START] && state_ff == ras_pkg::HST_IDLE;

  // one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req) begin
      case (wb_adr_i)
        ras_pkg::REG_WORD: rdata_ff <= {16'h0000, word_ff};
        ras_pkg::REG_CTRL: rdata_ff <= {29'h0000_0000, pup_ff, en_n_ff, 1'b0};
        ras_pkg::REG_STAT: rdata_ff <= {rx_ff, 14'h0000, done_ff, state_ff != ras_pkg::HST_IDLE};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // word to send; reserved bits cleared whatever software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff <= ras_pkg::WORD_ZERO;
    end else if (wr && wb_adr_i == ras_pkg::REG_WORD) begin
      if (wb_sel_i[0]) begin
        word_ff[7:0] <= wb_dat_i[7:0] & 8'hF7; // [RULE11]
      end
      if (wb_sel_i[1]) begin
        word_ff[15:8] <= wb_dat_i[15:8] & 8'hF7; // [RULE11]
      end
    end
  end

  // enable and power-up select levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_n_ff <= ras_pkg::CTRL_EN_N_RST;
      pup_ff <= ras_pkg::CTRL_PUP_RST;
    end else if (wr && wb_adr_i == ras_pkg::REG_CTRL && wb_sel_i[0]) begin
      en_n_ff <= wb_dat_i[ras_pkg::CTRL_EN_N];
      pup_ff <= wb_dat_i[ras_pkg::CTRL_PUP];
    end
  end

  // sticky done: set beats a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (wr && wb_adr_i == ras_pkg::REG_STAT && wb_sel_i[0] && wb_dat_i[ras_pkg::STAT_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // ***************************************************
  // link sequencer
  // ***************************************************
  logic [2:0] phase_ff;
  logic [3:0] bit_ff;
  logic [2:0] wait_ff;
  logic [15:0] tx_ff;
  logic sclk_ff;
  logic sdi_ff;
  logic latch_ff;
  logic chain_s1_ff;
  logic chain_s2_ff;

  assign finish = state_ff == ras_pkg::HST_LATCH_LO && wait_ff == ras_pkg::LATCH_HOLD;

  // chain input from the far module
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_s1_ff <= 1'b0;
      chain_s2_ff <= 1'b0;
    end else begin
      chain_s1_ff <= link.serial_chain_out;
      chain_s2_ff <= chain_s1_ff;
    end
  end

  // eight-cycle bit: data set at phase 0, clock rises at phase 4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ras_pkg::HST_IDLE;
      phase_ff <= 3'h0;
      bit_ff <= 4'h0;
      wait_ff <= 3'h0;
      tx_ff <= ras_pkg::WORD_ZERO;
      rx_ff <= ras_pkg::WORD_ZERO;
      sclk_ff <= 1'b0;
      sdi_ff <= 1'b0;
      latch_ff <= 1'b0;
    end else begin
      case (state_ff)
        ras_pkg::HST_IDLE: begin
          if (start) begin
            state_ff <= ras_pkg::HST_SHIFT;
            tx_ff <= word_ff;
            sdi_ff <= word_ff[15]; // [RULE16]
            phase_ff <= 3'h0;
            bit_ff <= 4'h0;
          end
        end
        ras_pkg::HST_SHIFT: begin
          phase_ff <= phase_ff + 3'h1;
          if (phase_ff == ras_pkg::PHASE_SAMPLE) begin
            sclk_ff <= 1'b1; // [RULE12]
            // old device word returns msb first, read only in a chain
            rx_ff <= {rx_ff[14:0], chain_s2_ff}; // [RULE14]
          end
          if (phase_ff == ras_pkg::PHASE_LAST) begin
            sclk_ff <= 1'b0;
            tx_ff <= {tx_ff[14:0], 1'b0};
            sdi_ff <= tx_ff[14];
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == ras_pkg::BIT_LAST) begin
              state_ff <= ras_pkg::HST_SETTLE;
              wait_ff <= 3'h0;
            end
          end
        end
        ras_pkg::HST_SETTLE: begin
          // last rise was four cycles back; this adds the settle time
          wait_ff <= wait_ff + 3'h1;
          if (wait_ff == ras_pkg::SETTLE_CYC3 - 3'h1) begin // [RULE15]
            state_ff <= ras_pkg::HST_LATCH_HI;
            latch_ff <= 1'b1;
            wait_ff <= 3'h0;
          end
        end
        ras_pkg::HST_LATCH_HI: begin
          // held for several cycles so the sampling device sees it
          wait_ff <= wait_ff + 3'h1;
          if (wait_ff == ras_pkg::LATCH_HOLD - 3'h1) begin
            state_ff <= ras_pkg::HST_LATCH_LO;
            latch_ff <= 1'b0;
            wait_ff <= 3'h0;
          end
        end
        ras_pkg::HST_LATCH_LO: begin
          wait_ff <= wait_ff + 3'h1;
          if (finish) begin
            state_ff <= ras_pkg::HST_IDLE;
          end
        end
        default: state_ff <= ras_pkg::HST_IDLE;
      endcase
    end
  end

  assign link.serial_clock = sclk_ff;
  assign link.serial_in = sdi_ff;
  assign link.latch_strobe = latch_ff;
  assign link.logic_enable_n = en_n_ff;
  assign link.powerup_state_select = pup_ff;
endmodule : ras_host

// ---- ras_pkg.sv ----
// Notes on behaviour
// RULE1: sixteen-stage shift register, last stage drives output
// RULE2: chain output always driven, meant for daisy-chains
// RULE3: enable low: shifting and latching work normally
// RULE4: enable high: ignore serial, force zero settings
// RULE5: select low: power up at zero settings
// RULE6: select high: power up at maximum settings
// RULE7: power-up state until first latch, then word
// RULE8: attenuation field is plain binary half-dB steps
// RULE9: phase field is plain binary negative 7-degree steps
// RULE10: a-group drives peaking path, b-group carrier path
// RULE11: host always sends zero in reserved bits
// RULE12: data presented around clock rise, sampled there
// RULE13: chain output updates after each clock rise
// RULE14: shared-bus host ignores chain output, write-only
// RULE15: last clock rise settles before latch rise
// RULE16: word goes most significant bit first
// RULE17: holding register loads on latch, drives settings
package ras_pkg;
  // ***************************************************
  // word layout
  // ***************************************************
  localparam int WORD_W = 16;
  localparam int A_ATT_LSB = 12;
  localparam int A_RSVD_BIT = 11;
  localparam int A_PH_LSB = 8;
  localparam int B_ATT_LSB = 4;
  localparam int B_RSVD_BIT = 3;
  localparam int B_PH_LSB = 0;
  localparam int ATT_W = 4;
  localparam int PH_W = 3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_MAX = 16'hF7F7;
  // ***************************************************
  // link pin order inside the device synchroniser
  // ***************************************************
  localparam int PIN_SCLK = 4;
  localparam int PIN_SDI = 3;
  localparam int PIN_LATCH = 2;
  localparam int PIN_EN_N = 1;
  localparam int PIN_PUP = 0;
  localparam int PIN_N = 5;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_SETTLE_NS = 27;
  localparam int SETTLE_RAW = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam logic [2:0] SETTLE_CYC3 = 3'(SETTLE_CYC);
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [2:0] PHASE_SAMPLE = 3'h3;
  localparam logic [2:0] LATCH_HOLD = 3'h4;
  localparam logic [3:0] BIT_LAST = 4'hF;
  // ***************************************************
  // host registers
  // ***************************************************
  localparam logic [3:0] REG_WORD = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTRL_START = 0;
  localparam int CTRL_EN_N = 1;
  localparam int CTRL_PUP = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_RX_LSB = 16;
  localparam logic CTRL_EN_N_RST = 1'b0;
  localparam logic CTRL_PUP_RST = 1'b1;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SHIFT = 3'b001,
    HST_SETTLE = 3'b010,
    HST_LATCH_HI = 3'b011,
    HST_LATCH_LO = 3'b100
  } ras_host_state_e;
endpackage : ras_pkg

// ---- ras_if.sv ----
`timescale 1ns/100ps
interface ras_if;
  logic serial_clock;
  logic serial_in;
  logic latch_strobe;
  logic logic_enable_n;
  logic powerup_state_select;
  logic serial_chain_out;

  modport device (
    input serial_clock, serial_in, latch_strobe, logic_enable_n, powerup_state_select,
    output serial_chain_out
  );
  modport host (
    output serial_clock, serial_in, latch_strobe, logic_enable_n, powerup_state_select,
    input serial_chain_out
  );
endinterface : ras_if

// ---- ras_device.sv ----
`timescale 1ns/100ps
module ras_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  ras_if.device link,
  // path settings
  output logic [3:0] peaking_atten_o,
  output logic [2:0] peaking_phase_o,
  output logic [3:0] carrier_atten_o,
  output logic [2:0] carrier_phase_o
);
  // ***************************************************
  // pin synchroniser
  // ***************************************************
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic sclk_prev_ff;
  logic latch_prev_ff;
  logic sclk_rise;
  logic latch_rise;
  logic enabled;

  // all pins share one delay, so data stays aligned with its clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {link.serial_clock, link.serial_in, link.latch_strobe,
                   link.logic_enable_n, link.powerup_state_select};
      sync2_ff <= sync1_ff;
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_ff <= 1'b0;
      latch_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sync2_ff[ras_pkg::PIN_SCLK];
      latch_prev_ff <= sync2_ff[ras_pkg::PIN_LATCH];
    end
  end

  // edge detect and enable qualify
  assign sclk_rise = sync2_ff[ras_pkg::PIN_SCLK] & ~sclk_prev_ff; // [RULE12]
  assign latch_rise = sync2_ff[ras_pkg::PIN_LATCH] & ~latch_prev_ff;
  assign enabled = ~sync2_ff[ras_pkg::PIN_EN_N]; // [RULE3] [RULE4]

  // ***************************************************
  // shift register
  // ***************************************************
  logic [15:0] shift_ff;

  // msb first: first bit sent ends at bit 15
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_ff <= ras_pkg::WORD_ZERO;
    end else if (enabled && sclk_rise) begin // [RULE3] [RULE4]
      shift_ff <= {shift_ff[14:0], sync2_ff[ras_pkg::PIN_SDI]}; // [RULE1] [RULE16]
    end
  end

  // always driven, never released; not for a shared return line
  assign link.serial_chain_out = shift_ff[ras_pkg::WORD_W-1]; // [RULE1] [RULE2] [RULE13]

  // ***************************************************
  // holding register and power-up state
  // ***************************************************
  logic latched_once_ff;
  logic [15:0] hold_ff;
  logic [15:0] applied_ff;

  // first accepted latch ends the power-up state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_once_ff <= 1'b0;
    end else if (enabled && latch_rise) begin
      latched_once_ff <= 1'b1; // [RULE7]
    end
  end

  // select pin is followed after reset release until the first latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff <= ras_pkg::WORD_ZERO;
    end else if (enabled && latch_rise) begin
      hold_ff <= shift_ff; // [RULE17] [RULE7]
    end else if (!latched_once_ff) begin
      hold_ff <= sync2_ff[ras_pkg::PIN_PUP] ? ras_pkg::WORD_MAX : ras_pkg::WORD_ZERO; // [RULE5] [RULE6]
    end
  end

  // disable forces zero but keeps the held word for re-enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_ff <= ras_pkg::WORD_ZERO;
    end else begin
      applied_ff <= enabled ? hold_ff : ras_pkg::WORD_ZERO; // [RULE4]
    end
  end

  // ***************************************************
  // field decode
  // ***************************************************
  // binary codes pass straight through; reserved bits go nowhere
  assign peaking_atten_o = applied_ff[ras_pkg::A_ATT_LSB +: ras_pkg::ATT_W]; // [RULE8] [RULE10]
  assign peaking_phase_o = applied_ff[ras_pkg::A_PH_LSB +: ras_pkg::PH_W]; // [RULE9] [RULE10]
  assign carrier_atten_o = applied_ff[ras_pkg::B_ATT_LSB +: ras_pkg::ATT_W]; // [RULE8] [RULE10]
  assign carrier_phase_o = applied_ff[ras_pkg::B_PH_LSB +: ras_pkg::PH_W]; // [RULE9] [RULE10]
endmodule : ras_device

// ---- ras_chk.sv ----
`timescale 1ns/100ps
module ras_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic logic_enable_n,
  input wire logic powerup_state_select,
  input wire logic serial_chain_out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] rises_ff;
  logic sclk_ff;
  logic latch_ff;

  // ****
  // helper history
  // ****
  // previous link levels, for edge finding
  always_ff @(posedge clk_i) begin
    sclk_ff <= serial_clock;
    latch_ff <= latch_strobe;
  end
  // serial rises since the last latch; a short word would slip past otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i || (latch_strobe && !latch_ff)) begin
      rises_ff <= 5'h00;
    end else if (serial_clock && !sclk_ff) begin
      rises_ff <= rises_ff + 5'h01;
    end
  end

  // ****
  // link rules
  // ****
  sequence s_pulse4(logic s);
    s [*4] ##1 !s;
  endsequence
  a_sclk_high_four: assert property ($rose(serial_clock) |-> s_pulse4(serial_clock))
    else $error("serial clock high phase not four cycles");
  a_sclk_low_gap: assert property ($fell(serial_clock) |-> !serial_clock [*4])
    else $error("serial clock low phase too short");
  a_data_held: assert property (serial_clock |-> $stable(serial_in))
    else $error("serial data moved while clock high");
  a_latch_pulse: assert property ($rose(latch_strobe) |-> s_pulse4(latch_strobe))
    else $error("latch pulse not four cycles");
  a_latch_settle: assert property ($rose(latch_strobe) |-> !serial_clock && !$past(serial_clock))
    else $error("latch rose without settling gap");
  a_latch_word: assert property ($rose(latch_strobe) |-> rises_ff == 5'h10)
    else $error("latch after wrong bit count");
  a_sclk_in_word: assert property ($rose(serial_clock) |-> rises_ff < 5'h10 && !latch_strobe)
    else $error("serial clock rose outside a word");
  a_chain_timing: assert property ($changed(serial_chain_out) |-> serial_clock && $past(serial_clock, 2))
    else $error("chain output moved away from clock rise");
  // enable pin reaches the shift logic through two stages, hence depth three
  a_chain_frozen_off: assert property ($changed(serial_chain_out) |-> !$past(logic_enable_n, 3))
    else $error("chain output moved while disabled");
endmodule : ras_chk

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] p_att;
  logic [3:0] c_att;
  logic [2:0] p_ph;
  logic [2:0] c_ph;
  logic [13:0] set_v;
  logic [31:0] q;
  logic [15:0] rb;
  logic [15:0] prev;
  logic [15:0] w;
  logic [2:0] ctrl_v;
  int fail_count = 0;
  int checks_done = 0;

  ras_if link ();
  ras_host ras_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link.host));
  ras_device ras_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link.device), .peaking_atten_o(p_att),
    .peaking_phase_o(p_ph), .carrier_atten_o(c_att), .carrier_phase_o(c_ph));
  ras_chk ras_chk_i (.clk_i(clk_i), .rst_i(rst_i), .serial_clock(link.serial_clock),
    .serial_in(link.serial_in), .latch_strobe(link.latch_strobe), .logic_enable_n(link.logic_enable_n),
    .powerup_state_select(link.powerup_state_select), .serial_chain_out(link.serial_chain_out));

  // all four path settings in word order
  assign set_v = {p_att, p_ph, c_att, c_ph};
  // 20 MHz clock
  always #(ras_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  // ****
  // helpers
  // ****
  function automatic logic [31:0] exp_set(input logic [15:0] v);
    return {18'h0, v[15:12], v[10:8], v[7:4], v[2:0]};
  endfunction : exp_set

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    // only the watchdog ends this wait; latency is checked afterwards
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    check("wishbone ack cycles", 32'h2, 32'(n));
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic set_ctrl(input logic [2:0] v);
    ctrl_v = v;
    bus(1'b1, ras_pkg::REG_CTRL, {29'h0, v});
    repeat (6) @(posedge clk_i);
  endtask : set_ctrl

  // full word transfer; polling is unbounded, only the watchdog stops a stuck sequencer
  task automatic send(input logic [15:0] v);
    int n;
    n = 0;
    bus(1'b1, ras_pkg::REG_WORD, {16'h0, v});
    bus(1'b1, ras_pkg::REG_CTRL, {29'h0, ctrl_v} | 32'h1);
    do begin
      bus(1'b0, ras_pkg::REG_STAT, 32'h0);
      n++;
      if (n == 1) begin
        check("busy flag", 32'h1, {31'h0, q[ras_pkg::STAT_BUSY]});
      end
    end while (q[ras_pkg::STAT_DONE] !== 1'b1);
    check("busy at done", 32'h0, {31'h0, q[ras_pkg::STAT_BUSY]});
    rb = q[31:16];
    bus(1'b1, ras_pkg::REG_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
  endtask : send

  // ****
  // tests
  // ****
  // main sequence
  initial begin
    ctrl_v = 3'b100;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("powerup max", exp_set(ras_pkg::WORD_MAX), {18'h0, set_v});
    set_ctrl(3'b000);
    check("powerup zero", 32'h0, {18'h0, set_v});
    prev = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      w = (i == 8) ? 16'hFFFF : {4'(2 * i), 1'b0, 3'(i), 4'(15 - 2 * i), 1'b0, 3'(7 - i)};
      send(w);
      check("settings", exp_set(w), {18'h0, set_v});
      check("readback", {16'h0, prev}, {16'h0, rb});
      prev = w & ras_pkg::WORD_MAX;
    end
    set_ctrl(3'b010);
    check("disabled", 32'h0, {18'h0, set_v});
    send(16'h1234);
    check("disabled latch", 32'h0, {18'h0, set_v});
    set_ctrl(3'b000);
    check("held word", exp_set(16'hF7F7), {18'h0, set_v});
    send(16'h0000);
    check("ignored shift", 32'h0000F7F7, {16'h0, rb});
    check("zero word", 32'h0, {18'h0, set_v});
    // low byte only; reserved bit cleared, high byte untouched
    sel <= 4'h1;
    bus(1'b1, ras_pkg::REG_WORD, 32'hFFFFFFFF);
    sel <= 4'hF;
    bus(1'b0, ras_pkg::REG_WORD, 32'h0);
    check("byte write", 32'h000000F7, q);
    bus(1'b1, 4'hC, 32'h5A5A5A5A);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", 32'h0, q);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("second powerup", exp_set(ras_pkg::WORD_MAX), {18'h0, set_v});
    bus(1'b0, ras_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", {29'h0, ras_pkg::CTRL_PUP_RST, ras_pkg::CTRL_EN_N_RST, 1'b0}, q);
    finish_test();
  end

  // watchdog, well beyond the roughly 1750 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    finish_test();
  end
endmodule : testbench
